// [efc_pkg.sv]
package efc_pkg;
  // ************************************************************
  // register byte addresses
  // ************************************************************
  localparam logic [7:0] ADDR_INT_STAT = 8'h04;
  localparam logic [7:0] ADDR_INT_EN = 8'h08;
  localparam logic [7:0] ADDR_TRIG = 8'h1c;
  localparam logic [7:0] ADDR_READBACK = 8'h20;
  localparam logic [7:0] ADDR_CONST_A = 8'h24;
  localparam logic [7:0] ADDR_CTRL = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h2c;

  // ************************************************************
  // control fields
  // ************************************************************
  localparam logic [2:0] MODE_LO_COUNT = 3'h4;
  localparam logic [2:0] MODE_HI_EVENT = 3'h0;
  localparam logic [2:0] MODE_HI_FREQ = 3'h7;
  localparam logic [1:0] POL_LOW = 2'h1;
  localparam logic [1:0] POL_HIGH = 2'h2;
  localparam logic [1:0] TRIG_DIR = 2'h3;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic int_en;
    logic wide;
    logic debounce;
    logic [2:0] mode_hi;
    logic [1:0] trig_cfg;
    logic [1:0] event_pol;
    logic [1:0] gate_pol;
    logic out_pol;
    logic [2:0] mode_lo;
  } efc_ctrl_type;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEBOUNCE_NS = 2400;
  localparam int PULSE_NS = 1600;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int PULSE_CYC = PULSE_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 9;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_RUN = 3'b100
  } efc_state_type;

  typedef struct packed {
    logic gate;
    logic evt;
    logic trig;
  } efc_pins_type;
endpackage

// [efc_counter.sv]
// Contract
// RULE1: mode low 100 with high 000 selects event counting.
// RULE2: control bit 3 sets output active level; pin idles high.
// RULE3: event mode bits 5..4 gate counting on low/high gate level.
// RULE4: event mode bits 7..6 choose event polarity, 00/11 disable.
// RULE5: bits 9..8 make third input trigger (01/10) or direction (11).
// RULE6: bit 13 rejects input pulses up to 2.4us.
// RULE7: bit 14 selects 16-bit or 32-bit counter.
// RULE8: bit 15 enables interrupt service, cleared by default.
// RULE9: count to constant A, pulse, optional interrupt, restart from zero.
// RULE10: counting down holds at zero.
// RULE11: mode low 100 with high 111 selects frequency measurement.
// RULE12: frequency mode counts signal edges while enable active.
// RULE13: enable polarity follows bits 5..4.
// RULE14: outside party drives enable with known-width pulse.
// RULE15: enable going inactive yields 1.6us output pulse, maybe interrupt.
// RULE16: third input or write to offset 1CH triggers channel.
// RULE17: after trigger, measurement starts at next enable active edge.
// RULE18: writing constant A while counting loads the counter.
// RULE19: readback returns live count.
// RULE20: source holds signal pulses 100ns, or 2.4us with debounce.
// RULE21: frequency mode ignores clock source selection.
// RULE22: interrupt on enable inactive if bit 15 and interrupt bit 0.
// RULE23: interrupt pending until status/clear at 04H is written.
// RULE24: clearing bit 15 cancels pending interrupt.
// RULE25: all field inputs synchronised before edge detection.
module efc_counter
  import efc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic gate_enable_input,
  input wire logic event_signal_input,
  input wire logic trigger_input,
  output logic counter_out,
  output logic irq
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    efc_pins_type s1;
    efc_pins_type s2;
    efc_pins_type filt;
    efc_pins_type filt_prev;
    logic [TMR_W-1:0] db_gate;
    logic [TMR_W-1:0] db_evt;
    logic [TMR_W-1:0] db_trig;
    efc_ctrl_type ctrl;
    logic [31:0] const_a;
    logic [31:0] count;
    logic int_mask;
    logic pending;
    efc_state_type st;
    logic [TMR_W-1:0] pulse;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic out_act;
  } efc_state_all_type;

  efc_state_all_type s_q, s_d;

  function automatic logic pol_level(input logic [1:0] pol,
                                     input logic lvl);
    pol_level = (pol == POL_LOW) ? ~lvl : lvl;
  endfunction

  function automatic logic pol_on(input logic [1:0] pol);
    pol_on = (pol == POL_LOW) || (pol == POL_HIGH);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  function automatic logic [TMR_W-1:0] filt_step(
      input logic raw, input logic cur, input logic [TMR_W-1:0] t,
      input logic en, output logic nv);
    logic [TMR_W-1:0] r;
    r = '0;
    nv = cur;
    if (!en) begin
      nv = raw;
    end else if (raw != cur) begin
      if (t >= TMR_W'(DEBOUNCE_CYC)) begin
        nv = raw;
      end else begin
        r = t + TMR_W'(1);
      end
    end
    filt_step = r;
  endfunction

  logic is_event, is_freq, gate_act, evt_edge, trig_edge, trig_hw;
  logic do_write, do_read, en_fall, en_rise, at_top, inc_ok, irq_set;
  logic [31:0] mask, cnt_m, wr_val;

  always_comb begin
    s_d = s_q;
    inc_ok = 1'b0;
    at_top = 1'b0;
    wr_val = '0;
    irq_set = 1'b0;
    // ************************************************************
    // input synchroniser and debounce
    // ************************************************************
    s_d.s1 = {gate_enable_input, event_signal_input, trigger_input};
    s_d.s2 = s_q.s1; // see RULE25
    s_d.filt_prev = s_q.filt;
    s_d.db_gate = filt_step(s_q.s2.gate, s_q.filt.gate, s_q.db_gate,
                            s_q.ctrl.debounce, s_d.filt.gate); // see RULE6
    s_d.db_evt = filt_step(s_q.s2.evt, s_q.filt.evt, s_q.db_evt,
                           s_q.ctrl.debounce, s_d.filt.evt);
    s_d.db_trig = filt_step(s_q.s2.trig, s_q.filt.trig, s_q.db_trig,
                            s_q.ctrl.debounce, s_d.filt.trig);

    is_event = s_q.ctrl.mode_lo == MODE_LO_COUNT
               && s_q.ctrl.mode_hi == MODE_HI_EVENT; // see RULE1
    is_freq = s_q.ctrl.mode_lo == MODE_LO_COUNT
              && s_q.ctrl.mode_hi == MODE_HI_FREQ; // see RULE11 RULE21
    mask = s_q.ctrl.wide ? 32'hffffffff : 32'h0000ffff; // see RULE7
    cnt_m = s_q.count & mask;

    // gate level and edges, polarity applied
    gate_act = pol_level(s_q.ctrl.gate_pol, s_q.filt.gate); // see RULE13
    en_rise = pol_on(s_q.ctrl.gate_pol) && gate_act
              && !pol_level(s_q.ctrl.gate_pol, s_q.filt_prev.gate);
    en_fall = pol_on(s_q.ctrl.gate_pol) && !gate_act
              && pol_level(s_q.ctrl.gate_pol, s_q.filt_prev.gate);
    evt_edge = pol_on(s_q.ctrl.event_pol)
               && pol_level(s_q.ctrl.event_pol, s_q.filt.evt)
               && !pol_level(s_q.ctrl.event_pol, s_q.filt_prev.evt);
    trig_hw = (s_q.ctrl.trig_cfg == POL_LOW)
              || (s_q.ctrl.trig_cfg == POL_HIGH);
    trig_edge = trig_hw && pol_level(s_q.ctrl.trig_cfg, s_q.filt.trig)
                && !pol_level(s_q.ctrl.trig_cfg, s_q.filt_prev.trig);

    // ************************************************************
    // axi4-lite slave
    // ************************************************************
    s_axi_awready = !s_q.aw_got && !s_q.bvalid;
    s_axi_wready = !s_q.w_got && !s_q.bvalid;
    s_axi_arready = !s_q.rvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    do_write = s_q.aw_got && s_q.w_got;
    do_read = s_axi_arvalid && s_axi_arready;
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // ************************************************************
    // counter engine
    // ************************************************************
    if (s_q.pulse != '0) begin
      s_d.pulse = s_q.pulse - TMR_W'(1);
    end
    if (!is_event && !is_freq) begin
      s_d.st = ST_IDLE;
    end
    case (s_q.st)
      ST_IDLE: begin
        if (trig_edge) begin // see RULE16
          s_d.st = is_freq ? ST_ARMED : ST_RUN;
          s_d.count = '0;
        end
      end
      ST_ARMED: begin
        if (en_rise) begin // see RULE17
          s_d.st = ST_RUN;
          s_d.count = '0;
        end
      end
      ST_RUN: begin
        if (is_event && evt_edge) begin
          inc_ok = !pol_on(s_q.ctrl.gate_pol) || gate_act; // see RULE3
          if (inc_ok && s_q.ctrl.trig_cfg == TRIG_DIR
              && s_q.filt.trig) begin // see RULE5
            if (cnt_m != '0) begin // see RULE10
              s_d.count = (cnt_m - 32'h1) & mask;
            end
          end else if (inc_ok) begin // see RULE4
            s_d.count = (cnt_m + 32'h1) & mask;
            at_top = ((cnt_m + 32'h1) & mask) == (s_q.const_a & mask);
            if (at_top) begin // see RULE9
              s_d.count = '0;
              s_d.pulse = TMR_W'(PULSE_CYC);
              if (s_q.ctrl.int_en && s_q.int_mask) begin
                s_d.pending = 1'b1;
                irq_set = 1'b1;
              end
            end
          end
        end
        if (is_freq) begin
          if (gate_act && s_q.filt.evt != s_q.filt_prev.evt
              && pol_on(s_q.ctrl.event_pol)) begin // see RULE12
            s_d.count = (cnt_m + 32'h1) & mask;
          end
          if (en_fall) begin
            s_d.pulse = TMR_W'(PULSE_CYC); // see RULE15
            s_d.st = ST_IDLE;
            if (s_q.ctrl.int_en && s_q.int_mask) begin // see RULE22
              s_d.pending = 1'b1;
              irq_set = 1'b1;
            end
          end
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // event mode: a hardware trigger also rearms a running channel
    if (is_event && s_q.st == ST_RUN && trig_edge) begin
      s_d.count = '0;
    end

    // ************************************************************
    // register writes
    // ************************************************************
    if (do_write) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      wr_val = merge(32'h0, s_q.wdata, s_q.wstrb);
      if (s_q.awaddr == ADDR_CTRL) begin
        s_d.ctrl = efc_ctrl_type'(16'(merge({16'h0, s_q.ctrl},
                                            s_q.wdata, s_q.wstrb)));
        // a new mode waits for its own trigger
        if (s_d.ctrl.mode_lo != s_q.ctrl.mode_lo
            || s_d.ctrl.mode_hi != s_q.ctrl.mode_hi) begin
          s_d.st = ST_IDLE;
        end
      end else if (s_q.awaddr == ADDR_CONST_A) begin
        s_d.const_a = merge(s_q.const_a, s_q.wdata, s_q.wstrb);
        if (s_q.st == ST_RUN) begin // see RULE18
          s_d.count = s_d.const_a & mask;
        end
      end else if (s_q.awaddr == ADDR_INT_EN) begin
        s_d.int_mask = s_q.wstrb[0] ? s_q.wdata[0] : s_q.int_mask;
      end else if (s_q.awaddr == ADDR_INT_STAT) begin
        if (wr_val[0] && !irq_set) begin // see RULE23
          s_d.pending = 1'b0;
        end
      end else if (s_q.awaddr == ADDR_TRIG) begin
        if (wr_val[0] && (is_event || is_freq)) begin // see RULE16
          s_d.st = is_freq ? ST_ARMED : ST_RUN;
          s_d.count = '0;
        end
      end else if (s_q.awaddr != ADDR_READBACK
                   && s_q.awaddr != ADDR_STATUS) begin
        s_d.bresp = RESP_SLVERR;
      end
    end
    if (!s_d.ctrl.int_en) begin
      s_d.pending = 1'b0; // see RULE24
    end

    // ************************************************************
    // register reads
    // ************************************************************
    if (do_read) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      if (s_axi_araddr == ADDR_READBACK) begin
        s_d.rdata = cnt_m; // see RULE19
      end else if (s_axi_araddr == ADDR_CTRL) begin
        s_d.rdata = {16'h0, s_q.ctrl};
      end else if (s_axi_araddr == ADDR_CONST_A) begin
        s_d.rdata = s_q.const_a;
      end else if (s_axi_araddr == ADDR_INT_EN) begin
        s_d.rdata = {31'h0, s_q.int_mask};
      end else if (s_axi_araddr == ADDR_INT_STAT) begin
        s_d.rdata = {31'h0, s_q.pending};
      end else if (s_axi_araddr == ADDR_STATUS) begin
        s_d.rdata = {26'h0, s_q.filt, s_q.st};
      end else if (s_axi_araddr == ADDR_TRIG) begin
        s_d.rdata = 32'h0;
      end else begin
        s_d.rdata = 32'h0;
        s_d.rresp = RESP_SLVERR;
      end
    end

    // output pin level, idles high
    s_d.out_act = (s_d.pulse != '0) ? s_d.ctrl.out_pol : 1'b1; // see RULE2
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.ctrl <= efc_ctrl_type'(CTRL_RESET); // see RULE8
      s_q.st <= ST_IDLE;
      s_q.out_act <= 1'b1;
      s_q.bresp <= RESP_OKAY;
      s_q.rresp <= RESP_OKAY;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign counter_out = s_q.out_act;
  assign irq = s_q.pending;
endmodule

// [efc_counter_properties.sv]
module efc_counter_properties
  import efc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic counter_out,
  input wire logic irq
);
  logic [8:0] low_q;
  logic [3:0] age_q;
  logic mapped;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  assign mapped = s_axi_araddr inside {ADDR_INT_STAT, ADDR_INT_EN,
    ADDR_TRIG, ADDR_READBACK, ADDR_CONST_A, ADDR_CTRL, ADDR_STATUS};
  // low time of the pin and cycles since last write data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_q <= 9'h000;
      age_q <= 4'h0;
    end else begin
      low_q <= counter_out ? 9'h000 : low_q + 9'h001;
      age_q <= (s_axi_wvalid && s_axi_wready) ? 4'h0 :
               (age_q == 4'hf) ? age_q : age_q + 4'h1;
    end
  end
  // *****
  // steps of a bus transfer
  // *****
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_write_refused: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write taken");
  a_unmapped_err: assert property (rd_taken ##0 !mapped
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_pulse_width: assert property (
    $rose(counter_out) |-> low_q == PULSE_CYC) else $error("pulse width");
  a_irq_clear: assert property (
    wr_taken ##0 (s_axi_awaddr == ADDR_INT_STAT && s_axi_wdata[0])
    |-> ##[1:3] !irq) else $error("irq not cleared");
  a_irq_by_write: assert property (
    $fell(irq) |-> age_q <= 4'h4) else $error("irq lost unasked");
  a_reset_idle: assert property (
    $rose(aresetn) |-> counter_out && !irq) else $error("bad idle");
endmodule

bind efc_counter efc_counter_properties efc_counter_properties_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .counter_out(counter_out), .irq(irq));

// [efc_field_model.sv]
module efc_field_model
  import efc_pkg::*;
(
  input wire logic aclk,
  output efc_pins_type pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pins = '0;
  end
  // line 2 gate or enable, 1 event, 0 trigger or direction
  task automatic level(input int sel, input logic v);
    @(posedge aclk);
    pins[sel] <= v;
  endtask
  // known-width pulse: line toggled for hi+1 cycles, then toggled back for lo cycles
  task automatic pulse(input int sel, input int hi, input int lo);
    level(sel, ~pins[sel]);
    repeat (hi) @(posedge aclk);
    level(sel, ~pins[sel]);
    repeat (lo) @(posedge aclk);
  endtask
endmodule

// [tb.sv]
module tb
  import efc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 40000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, counter_out, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  efc_pins_type pins;
  logic [33:0] expq[$];
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  efc_counter efc_counter_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .gate_enable_input(pins.gate),
    .event_signal_input(pins.evt), .trigger_input(pins.trig),
    .counter_out(counter_out), .irq(irq));
  efc_field_model efc_field_model_i (.aclk(aclk), .pins(pins));

  initial begin
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      conclude();
    end
  end
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      check({rresp, rdata}, expq.pop_front());
    end
  end
  // *****
  // checking and bus tasks
  // *****
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awready && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !dd) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge aclk);
    expq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask
  task automatic pulse_len(output int n);
    n = 0;
    while (counter_out === 1'b1) @(posedge aclk);
    while (counter_out !== 1'b1) begin
      n++;
      @(posedge aclk);
    end
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(posedge aclk);
    check({33'h0, irq}, {33'h0, v});
  endtask
  // *****
  // main sequence
  // *****
  initial begin
    int a;
    int n;
    a = $urandom(32'h896f);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({33'h0, counter_out}, 34'h1);
    rd(ADDR_CTRL, {RESP_OKAY, 16'h0, CTRL_RESET});
    rd(8'h40, {RESP_SLVERR, 32'h0});
    wr(ADDR_INT_EN, 32'h1);
    a = 4 + $urandom % 4;
    wr(ADDR_CONST_A, 32'(a));
    wr(ADDR_CTRL, 32'ha394);
    wr(ADDR_TRIG, 32'h1);
    efc_field_model_i.level(0, 1'b1);
    repeat (300) @(posedge aclk);
    efc_field_model_i.pulse(1, 300, 300);
    rd(ADDR_READBACK, {RESP_OKAY, 32'h0});
    efc_field_model_i.level(0, 1'b0);
    efc_field_model_i.level(2, 1'b1);
    repeat (300) @(posedge aclk);
    repeat (2) efc_field_model_i.pulse(1, 300, 300);
    efc_field_model_i.level(2, 1'b0);
    repeat (300) @(posedge aclk);
    efc_field_model_i.pulse(1, 100, 300);
    repeat (3) efc_field_model_i.pulse(1, 300, 300);
    rd(ADDR_READBACK, {RESP_OKAY, 32'h3});
    fork
      repeat (a - 3) efc_field_model_i.pulse(1, 300, 300);
      pulse_len(n);
    join
    check(34'(n), 34'(PULSE_CYC));
    rd(ADDR_READBACK, {RESP_OKAY, 32'h0});
    irq_is(1'b1);
    wr(ADDR_INT_STAT, 32'h1);
    irq_is(1'b0);
    wr(ADDR_CONST_A, 32'(a));
    rd(ADDR_READBACK, {RESP_OKAY, 32'(a)});
    wr(ADDR_CTRL, 32'h9ea4);
    efc_field_model_i.pulse(1, 20, 20);
    efc_field_model_i.pulse(0, 20, 20);
    efc_field_model_i.pulse(1, 20, 20);
    fork
      begin
        efc_field_model_i.level(2, 1'b1);
        repeat (20) @(posedge aclk);
        repeat (4) efc_field_model_i.pulse(1, 20, 20);
        efc_field_model_i.level(2, 1'b0);
      end
      pulse_len(n);
    join
    check(34'(n), 34'(PULSE_CYC));
    rd(ADDR_READBACK, {RESP_OKAY, 32'h8});
    irq_is(1'b1);
    wr(ADDR_CTRL, 32'h1ea4);
    irq_is(1'b0);
    repeat (2) @(posedge aclk);
    conclude();
  end
endmodule
